// >>> pkg/gmc_pkg.sv
// package: constants, types and summary for the graphics memory controller
//Contract
// - grant refresh, capture, display, host, draw in order
// - host sees memory as linear random-access window
// - 16-bit pixel is alpha plus three 5-bit fields
// - 8-bit pixel is a palette index
// - depth is unsigned, 8-bit or 16-bit mode
// - depth takes two bytes or one per pixel
// - flag buffer one bit per pixel, guard lines
// - texture 16-bit alpha only during texture mapping
// - capture word packs Y0 Cb low, Y1 Cr high
// - 32-bit pixel B G R alpha; never drawn
// - frames up to 4096 square, 32-pixel granular
// - textures addressable up to 4096 square
// - six display layers, own frame each
// - two 64x64 8-bit cursor patterns fetched
// - single buffer fetch wraps at frame edges
// - buffer swap only in blanking, auto or asked
// - double buffering per layer two to five
// - row bits on low outputs, bank above
// - 256M x16 uses 13 bits, bank on 14:13
// - 64M x32 uses 11 bits, bank on 12:11
// - fast-cycle part uses 11 bits, bank on 11
`default_nettype none
package gmc_pkg;
  localparam int CLK_NS = 5;
  localparam int TRCD_NS = 15;
  localparam int TRCD_CYC = (TRCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRP_NS = 15;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRFC_NS = 60;
  localparam int TRFC_CYC = (TRFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_NS = 7800;
  localparam int REF_CYC = REF_NS / CLK_NS;
  localparam int CAS_CYC = 2;
  localparam int AW = 25;
  localparam int DW = 32;
  localparam int MAW = 15;
  localparam int NLAYER = 6;
  localparam int NCUR = 2;
  localparam int NREQ = 5;
  localparam int REQ_REF = 0;
  localparam int REQ_CAP = 1;
  localparam int REQ_DISP = 2;
  localparam int REQ_HOST = 3;
  localparam int REQ_DRW = 4;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [7:0] CNT_RST = 8'h00;
  typedef enum logic [2:0] {
    MT_SD64X16, MT_SD128X16, MT_SD256X16, MT_SD64X32, MT_SD128X32, MT_FC16X16
  } gmc_memtype_t;
  typedef enum logic [1:0] {PF_IDX8, PF_RGB16, PF_RGB32} gmc_pixfmt_t;
  typedef enum logic [1:0] {DK_FRAME, DK_DEPTH, DK_FLAG, DK_TEX} gmc_drwkind_t;
endpackage
`default_nettype wire

// >>> pkg/gmc_arb_if.sv
// interface: requests, grant and completion between arbiter and sequencer
`default_nettype none
interface gmc_arb_if;
  logic [gmc_pkg::NREQ-1:0] req;
  logic [gmc_pkg::NREQ-1:0] gnt;
  logic start;
  logic done;
  logic busy;
  modport arb (input req, input done, output gnt, output start, output busy);
  modport ctl (output req, output done, input gnt, input start, input busy);
endinterface
`default_nettype wire

// >>> verilog/gmc_arb.sv
// module: fixed-priority memory arbiter holding a grant until the access ends
`default_nettype none
module gmc_arb (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // requests and grant
  gmc_arb_if.arb arb
);
  import gmc_pkg::*;

  logic busy_ff;
  logic [NREQ-1:0] owner_ff;
  logic [NREQ-1:0] pick;

  // lowest index is highest priority
  function automatic logic [NREQ-1:0] first_set(input logic [NREQ-1:0] r);
    return r & (~r + NREQ'(1));
  endfunction

  assign pick = first_set(arb.req);
  assign arb.start = !busy_ff && (|arb.req);
  assign arb.gnt = busy_ff ? owner_ff : pick;
  assign arb.busy = busy_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
      owner_ff <= '0;
    end else if (arb.start) begin
      busy_ff <= 1'b1;
      owner_ff <= pick;
    end else if (arb.done) begin
      busy_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_prio_first;
    @(posedge i_clk) disable iff (i_rst)
    arb.start |-> (((arb.gnt - NREQ'(1)) & arb.req) == '0) && $onehot(arb.gnt);
  endproperty
  a_prio_first: assert property (p_prio_first) else $error("lower requester won");

  property p_ref_wins;
    @(posedge i_clk) disable iff (i_rst)
    arb.start && arb.req[REQ_REF] |-> arb.gnt[REQ_REF];
  endproperty
  a_ref_wins: assert property (p_ref_wins) else $error("refresh not granted");

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
    arb.busy && !arb.done |=> arb.busy && $stable(arb.gnt);
  endproperty
  a_hold: assert property (p_hold) else $error("grant moved mid access");

  property p_no_start_busy;
    @(posedge i_clk) disable iff (i_rst)
    arb.busy |-> !arb.start;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy) else $error("start while busy");
endmodule
`default_nettype wire

// >>> verilog/gmc_top.sv
// module: graphics memory controller, requesters, address maps, sequencer
`default_nettype none
module gmc_top (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // configuration
  input wire gmc_pkg::gmc_memtype_t i_MEMORY_TYPE_CONFIG,
  // host window
  input wire logic i_HOST_REQ,
  input wire logic i_HOST_WE,
  input wire logic [gmc_pkg::AW-1:0] i_HOST_ADDR,
  input wire logic [3:0] i_HOST_BE,
  input wire logic [gmc_pkg::DW-1:0] i_HOST_WDATA,
  // video capture
  input wire logic i_CAP_REQ,
  input wire logic [gmc_pkg::AW-1:0] i_CAP_ADDR,
  input wire logic [7:0] i_CAP_Y0,
  input wire logic [7:0] i_CAP_CB,
  input wire logic [7:0] i_CAP_Y1,
  input wire logic [7:0] i_CAP_CR,
  // display fetch
  input wire logic i_DISP_REQ,
  input wire logic i_DISP_CURSOR,
  input wire logic [2:0] i_DISP_LAYER,
  input wire logic [12:0] i_DISP_X,
  input wire logic [12:0] i_DISP_Y,
  input wire logic i_VBLANK,
  input wire logic i_AUTO_FLIP,
  input wire logic [5:2] i_FLIP_REQ,
  input wire logic [5:2] i_DBUF_EN,
  input wire logic [gmc_pkg::NLAYER-1:0][gmc_pkg::AW-1:0] i_LAYER_ORG_A,
  input wire logic [gmc_pkg::NLAYER-1:0][gmc_pkg::AW-1:0] i_LAYER_ORG_B,
  input wire gmc_pkg::gmc_pixfmt_t [gmc_pkg::NLAYER-1:0] i_LAYER_FMT,
  input wire logic [gmc_pkg::NLAYER-1:0][7:0] i_LAYER_W32,
  input wire logic [gmc_pkg::NLAYER-1:0][12:0] i_LAYER_H,
  input wire logic [gmc_pkg::NCUR-1:0][gmc_pkg::AW-1:0] i_CUR_BASE,
  // drawing engine
  input wire logic i_DRW_REQ,
  input wire logic i_DRW_WE,
  input wire gmc_pkg::gmc_drwkind_t i_DRW_KIND,
  input wire logic i_DRW_16BPP,
  input wire logic [11:0] i_DRW_X,
  input wire logic [11:0] i_DRW_Y,
  input wire logic [15:0] i_DRW_WDATA,
  input wire logic [gmc_pkg::AW-1:0] i_DRW_BASE,
  input wire logic [7:0] i_DRW_W32,
  // memory pins
  output logic [gmc_pkg::MAW-1:0] o_MEMORY_ADDRESS_OUTPUTS,
  output logic o_MEM_CS_N,
  output logic o_MEM_RAS_N,
  output logic o_MEM_CAS_N,
  output logic o_MEM_WE_N,
  output logic [3:0] o_MEM_DQM,
  output logic [gmc_pkg::DW-1:0] o_MEM_DQ_OUT,
  output logic o_MEM_DQ_OE,
  input wire logic [gmc_pkg::DW-1:0] i_MEM_DQ_IN,
  // answers
  output logic [gmc_pkg::NREQ-1:0] o_ACK,
  output logic [gmc_pkg::DW-1:0] o_RDATA,
  output logic [7:0] o_PIX_R,
  output logic [7:0] o_PIX_G,
  output logic [7:0] o_PIX_B,
  output logic o_PIX_ALPHA,
  output logic [7:0] o_PIX_IDX,
  output logic o_PIX_IS_IDX,
  output logic [15:0] o_DRW_Z,
  output logic o_TEX_ALPHA,
  output logic [gmc_pkg::NLAYER-1:0] o_DISP_BUF_SEL
);
  import gmc_pkg::*;

  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  typedef enum logic [2:0] {ST_IDLE, ST_REF, ST_RCD, ST_CAS, ST_RP} gmc_state_t;

  gmc_arb_if arb_if();

  gmc_arb u_arb (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .arb(arb_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // offset past frame edge folds back to the start
  function automatic logic [12:0] wrap_off(input logic [12:0] v, input logic [12:0] lim);
    return (v >= lim) ? v - lim : v;
  endfunction

  function automatic logic [MAW-1:0] ma_map(input gmc_memtype_t t, input logic [12:0] a,
                                            input logic [1:0] ba);
    logic [MAW-1:0] m;
    m = '0;
    unique case (t)
      MT_SD256X16: m = {ba, a};
      MT_SD64X32: m = {2'b00, ba, a[10:0]};
      MT_FC16X16: m = {3'b000, ba[0], a[10:0]};
      MT_SD64X16, MT_SD128X16, MT_SD128X32: m = {1'b0, ba, a[11:0]};
      default: m = '0;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] ex5(input logic [4:0] c);
    return {c, c[4:2]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // refresh timer
  logic [10:0] ref_cnt_ff;
  logic ref_pend_ff;
  logic ref_tick;
  assign ref_tick = (ref_cnt_ff == 11'(REF_CYC - 1));

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ref_cnt_ff <= '0;
      ref_pend_ff <= 1'b0;
    end else begin
      ref_cnt_ff <= ref_tick ? '0 : ref_cnt_ff + 11'h001;
      ref_pend_ff <= ref_tick || (ref_pend_ff && !(arb_if.start && arb_if.gnt[REQ_REF]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // double buffer flip, only while blanking
  logic [NLAYER-1:0] buf_sel_ff;
  logic [5:2] flip_pend_ff;
  logic vblank_d_ff;
  logic [5:2] flip_now;
  assign flip_now = {4{i_VBLANK}} & i_DBUF_EN &
                    (flip_pend_ff | {4{i_AUTO_FLIP && i_VBLANK && !vblank_d_ff}});

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      buf_sel_ff <= '0;
      flip_pend_ff <= '0;
      vblank_d_ff <= 1'b0;
    end else begin
      vblank_d_ff <= i_VBLANK;
      buf_sel_ff[5:2] <= buf_sel_ff[5:2] ^ flip_now;
      flip_pend_ff <= (i_FLIP_REQ & i_DBUF_EN) | (flip_pend_ff & ~flip_now);
    end
  end
  assign o_DISP_BUF_SEL = buf_sel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // display and cursor fetch address
  logic [12:0] disp_w;
  logic [12:0] disp_xw;
  logic [12:0] disp_yw;
  logic [AW-1:0] disp_pix;
  logic [AW-1:0] disp_org;
  logic [AW-1:0] cur_addr;
  logic [AW-1:0] disp_addr;
  gmc_pixfmt_t disp_fmt;
  assign disp_w = {i_LAYER_W32[i_DISP_LAYER][7:0], 5'h00};
  assign disp_xw = wrap_off(i_DISP_X, disp_w);
  assign disp_yw = wrap_off(i_DISP_Y, i_LAYER_H[i_DISP_LAYER]);
  assign disp_pix = AW'(disp_yw) * AW'(disp_w) + AW'(disp_xw);
  assign disp_org = buf_sel_ff[i_DISP_LAYER] ? i_LAYER_ORG_B[i_DISP_LAYER] :
                    i_LAYER_ORG_A[i_DISP_LAYER];
  assign cur_addr = i_CUR_BASE[i_DISP_LAYER[0]] + AW'({i_DISP_Y[5:0], i_DISP_X[5:0]});
  assign disp_fmt = i_DISP_CURSOR ? PF_IDX8 : i_LAYER_FMT[i_DISP_LAYER];
  assign disp_addr = i_DISP_CURSOR ? cur_addr :
                     disp_org + (disp_pix << disp_fmt);

  ////////////////////////////////////////////////////////////////////////////
  // drawing address: frame, depth, flag and texture
  logic [12:0] drw_w;
  logic [AW-1:0] drw_pix;
  logic [AW-1:0] flag_pix;
  logic [AW-1:0] drw_off;
  logic [AW-1:0] drw_addr;
  logic drw_half;
  logic [3:0] drw_be;
  assign drw_w = {i_DRW_W32, 5'h00};
  assign drw_pix = AW'(i_DRW_Y) * AW'(drw_w) + AW'(i_DRW_X);
  assign flag_pix = (AW'(i_DRW_Y) + AW'(1)) * AW'(drw_w) + AW'(i_DRW_X);
  // only 8 and 16 bits per pixel can be drawn
  assign drw_half = i_DRW_16BPP && (i_DRW_KIND != DK_FLAG);
  assign drw_off = (i_DRW_KIND == DK_FLAG) ? (flag_pix >> 3) :
                   (drw_half ? (drw_pix << 1) : drw_pix);
  assign drw_addr = i_DRW_BASE + drw_off;
  assign drw_be = drw_half ? (drw_addr[1] ? 4'hc : 4'h3) : (4'h1 << drw_addr[1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // request selection
  logic [NREQ-1:0] g;
  logic [AW-1:0] sel_addr;
  logic sel_we;
  logic [DW-1:0] sel_wdata;
  logic [3:0] sel_be;
  logic [DW-1:0] cap_word;
  assign arb_if.req = {i_DRW_REQ, i_HOST_REQ, i_DISP_REQ, i_CAP_REQ, ref_pend_ff};
  assign g = arb_if.gnt;
  assign cap_word = {i_CAP_Y1, i_CAP_CR, i_CAP_Y0, i_CAP_CB};
  assign sel_addr = g[REQ_CAP] ? i_CAP_ADDR : g[REQ_DISP] ? disp_addr :
                    g[REQ_HOST] ? i_HOST_ADDR : drw_addr;
  assign sel_we = g[REQ_CAP] || (g[REQ_HOST] && i_HOST_WE) || (g[REQ_DRW] && i_DRW_WE);
  assign sel_wdata = g[REQ_CAP] ? cap_word : g[REQ_HOST] ? i_HOST_WDATA :
                     (drw_half ? {2{i_DRW_WDATA}} : {4{i_DRW_WDATA[7:0]}});
  assign sel_be = g[REQ_CAP] ? 4'hf : g[REQ_HOST] ? i_HOST_BE : drw_be;

  ////////////////////////////////////////////////////////////////////////////
  // access latch
  logic [AW-1:0] addr_ff;
  logic we_ff;
  logic [DW-1:0] wdata_ff;
  logic [3:0] be_ff;
  gmc_pixfmt_t fmt_ff;
  gmc_drwkind_t kind_ff;
  logic z16_ff;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      addr_ff <= '0;
      we_ff <= 1'b0;
      wdata_ff <= '0;
      be_ff <= '0;
      fmt_ff <= PF_IDX8;
      kind_ff <= DK_FRAME;
      z16_ff <= 1'b0;
    end else if (arb_if.start) begin
      addr_ff <= sel_addr;
      we_ff <= sel_we;
      wdata_ff <= sel_wdata;
      be_ff <= sel_be;
      fmt_ff <= disp_fmt;
      kind_ff <= i_DRW_KIND;
      z16_ff <= i_DRW_16BPP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  gmc_state_t st_ff;
  gmc_state_t nxt_st;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [3:0] nxt_cmd;
  logic [MAW-1:0] nxt_ma;
  logic nxt_oe;
  logic rd_cap;
  logic wr_issue;
  logic cnt_zero;
  assign cnt_zero = (cnt_ff == 8'h00);
  assign arb_if.done = ((st_ff == ST_RP) || (st_ff == ST_REF)) && cnt_zero;
  assign rd_cap = (st_ff == ST_CAS) && cnt_zero;
  assign wr_issue = (st_ff == ST_RCD) && cnt_zero && we_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_zero ? cnt_ff : cnt_ff - 8'h01;
    nxt_cmd = CMD_NOP;
    nxt_ma = '0;
    nxt_oe = 1'b0;
    unique case (st_ff)
      ST_IDLE: begin
        if (arb_if.start && g[REQ_REF]) begin
          nxt_cmd = CMD_REF;
          nxt_st = ST_REF;
          nxt_cnt = 8'(TRFC_CYC - 1);
        end else if (arb_if.start) begin
          nxt_cmd = CMD_ACT;
          nxt_ma = ma_map(i_MEMORY_TYPE_CONFIG, sel_addr[24:12], sel_addr[11:10]);
          nxt_st = ST_RCD;
          nxt_cnt = 8'(TRCD_CYC - 1);
        end
      end
      ST_RCD: begin
        if (cnt_zero) begin
          nxt_cmd = we_ff ? CMD_WR : CMD_RD;
          // column with auto precharge on address bit ten
          nxt_ma = ma_map(i_MEMORY_TYPE_CONFIG, {5'h01, addr_ff[9:2]} << 2, addr_ff[11:10]);
          nxt_oe = we_ff;
          nxt_st = we_ff ? ST_RP : ST_CAS;
          nxt_cnt = we_ff ? 8'(TRP_CYC) : 8'(CAS_CYC);
        end
      end
      ST_CAS: begin
        if (cnt_zero) begin
          nxt_st = ST_RP;
          nxt_cnt = 8'(TRP_CYC - 1);
        end
      end
      ST_RP, ST_REF: begin
        if (cnt_zero) begin
          nxt_st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      st_ff <= ST_IDLE;
      cnt_ff <= CNT_RST;
      {o_MEM_CS_N, o_MEM_RAS_N, o_MEM_CAS_N, o_MEM_WE_N} <= CMD_NOP;
      o_MEMORY_ADDRESS_OUTPUTS <= '0;
      o_MEM_DQ_OE <= 1'b0;
      o_MEM_DQ_OUT <= '0;
      o_MEM_DQM <= 4'hf;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      {o_MEM_CS_N, o_MEM_RAS_N, o_MEM_CAS_N, o_MEM_WE_N} <= nxt_cmd;
      o_MEMORY_ADDRESS_OUTPUTS <= nxt_ma;
      o_MEM_DQ_OE <= nxt_oe;
      o_MEM_DQ_OUT <= nxt_oe ? wdata_ff : '0;
      o_MEM_DQM <= nxt_oe ? ~be_ff : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data decode
  logic [7:0] rd_byte;
  logic [15:0] rd_half;
  assign rd_byte = 8'(i_MEM_DQ_IN >> {addr_ff[1:0], 3'b000});
  assign rd_half = addr_ff[1] ? i_MEM_DQ_IN[31:16] : i_MEM_DQ_IN[15:0];

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      o_ACK <= '0;
      o_RDATA <= '0;
      {o_PIX_R, o_PIX_G, o_PIX_B, o_PIX_ALPHA, o_PIX_IDX, o_PIX_IS_IDX} <= '0;
      o_DRW_Z <= '0;
      o_TEX_ALPHA <= 1'b0;
    end else begin
      o_ACK <= (rd_cap || wr_issue) ? g : '0;
      if (rd_cap) begin
        o_RDATA <= i_MEM_DQ_IN;
      end
      if (rd_cap && g[REQ_DISP]) begin
        unique case (fmt_ff)
          PF_IDX8: {o_PIX_R, o_PIX_G, o_PIX_B, o_PIX_ALPHA, o_PIX_IDX, o_PIX_IS_IDX} <=
                   {25'h0, rd_byte, 1'b1};
          PF_RGB16: {o_PIX_R, o_PIX_G, o_PIX_B, o_PIX_ALPHA, o_PIX_IDX, o_PIX_IS_IDX} <=
                    {ex5(rd_half[14:10]), ex5(rd_half[9:5]), ex5(rd_half[4:0]),
                     rd_half[15], 9'h0};
          PF_RGB32: {o_PIX_R, o_PIX_G, o_PIX_B, o_PIX_ALPHA, o_PIX_IDX, o_PIX_IS_IDX} <=
                    {i_MEM_DQ_IN[23:0], i_MEM_DQ_IN[31], 9'h0};
          default: o_PIX_IS_IDX <= 1'b0;
        endcase
      end
      if (rd_cap && g[REQ_DRW] && kind_ff == DK_DEPTH) begin
        o_DRW_Z <= z16_ff ? rd_half : {8'h00, rd_byte};
      end
      if (rd_cap && g[REQ_DRW] && kind_ff == DK_TEX) begin
        o_TEX_ALPHA <= z16_ff && rd_half[15];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_swap_blank;
    !$stable(buf_sel_ff) |-> $past(i_VBLANK);
  endproperty
  a_swap_blank: assert property (p_swap_blank) else $error("swap outside blanking");

  property p_low_single;
    buf_sel_ff[1:0] == 2'b00;
  endproperty
  a_low_single: assert property (p_low_single) else $error("layer 0 or 1 flipped");

  property p_ma_256;
    arb_if.start && !g[REQ_REF] && i_MEMORY_TYPE_CONFIG == MT_SD256X16
    |=> o_MEMORY_ADDRESS_OUTPUTS == {$past(sel_addr[11:10]), $past(sel_addr[24:12])};
  endproperty
  a_ma_256: assert property (p_ma_256) else $error("bad 256M row map");

  property p_ma_64x32;
    arb_if.start && !g[REQ_REF] && i_MEMORY_TYPE_CONFIG == MT_SD64X32
    |=> o_MEMORY_ADDRESS_OUTPUTS[14:11] == {2'b00, $past(sel_addr[11:10])};
  endproperty
  a_ma_64x32: assert property (p_ma_64x32) else $error("bad 64M x32 bank map");

  property p_ma_fc;
    arb_if.start && !g[REQ_REF] && i_MEMORY_TYPE_CONFIG == MT_FC16X16
    |=> o_MEMORY_ADDRESS_OUTPUTS[14:11] == {3'b000, $past(sel_addr[10])};
  endproperty
  a_ma_fc: assert property (p_ma_fc) else $error("bad fast-cycle bank map");

  property p_ref_served;
    $rose(ref_pend_ff) |-> ##[0:40] (arb_if.start && g[REQ_REF]);
  endproperty
  a_ref_served: assert property (p_ref_served) else $error("refresh starved");

  property p_host_write;
    arb_if.start && g[REQ_HOST] && i_HOST_WE
    |-> ##(TRCD_CYC + 1) o_MEM_DQ_OE && o_MEM_DQ_OUT == $past(i_HOST_WDATA, TRCD_CYC + 1);
  endproperty
  a_host_write: assert property (p_host_write) else $error("host write data lost");

  property p_cap_pack;
    arb_if.start && g[REQ_CAP] |=> wdata_ff[31:24] == $past(i_CAP_Y1) &&
                                    wdata_ff[7:0] == $past(i_CAP_CB);
  endproperty
  a_cap_pack: assert property (p_cap_pack) else $error("capture word misordered");
endmodule
`default_nettype wire

// >>> testbench/gmc_mem_model.sv
// memory chip model: words keyed by row and column pins
`default_nettype none
module gmc_mem_model (
  // command side
  input wire logic i_clk,
  input wire logic [14:0] i_ma,
  input wire logic [3:0] i_cmd,
  input wire logic [3:0] i_dqm,
  input wire logic [31:0] i_dq,
  // read data
  output logic [31:0] o_dq
);
  timeunit 1ns;
  timeprecision 100ps;
  import gmc_pkg::*;
  logic [31:0] mem [logic [29:0]];
  logic [14:0] row = '0;
  logic [29:0] k;
  int left = 0;
  assign k = {row, i_ma & 15'h7bff};
  initial o_dq = '0;
  // read data stands four cycles, then toggles like a released bus
  always @(posedge i_clk) begin
    if (i_cmd == CMD_ACT) row <= i_ma;
    if (i_cmd == CMD_WR) begin
      if (!mem.exists(k)) mem[k] = '0;
      for (int b = 0; b < 4; b++)
        if (!i_dqm[b]) mem[k][8*b+:8] = i_dq[8*b+:8];
    end
    if (i_cmd == CMD_RD) begin
      o_dq <= mem.exists(k) ? mem[k] : 32'h0;
      left <= 3;
    end else if (left > 0) left <= left - 1;
    else o_dq <= ~o_dq;
  end
endmodule
`default_nettype wire

// >>> testbench/graphics_memory_controller_tb.sv
// testbench: host window, priority, capture packing, pixel decode, flips
`default_nettype none
module graphics_memory_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import gmc_pkg::*;
  logic clk = 0, rst = 1, we = 0, vbl = 0, aflip = 0, cur = 0, d16 = 1, dwe = 1, oe, pal, pisx;
  gmc_memtype_t mt = MT_SD64X16;
  gmc_drwkind_t dkind = DK_FRAME;
  gmc_pixfmt_t [NLAYER-1:0] fmt;
  logic [4:0] req = '0, ack;
  logic [24:0] haddr = '0, caddr = '0, dbase = 25'h100000;
  logic [3:0] be = 4'hf, dqm;
  logic [31:0] hwd = '0, dqo, dqi, rdata, v, r;
  logic [7:0] y0 = 0, cb = 0, y1 = 0, cr = 0, dw32 = 8'h01;
  logic [5:2] freq = '0, dben = '0;
  logic [2:0] dl = '0;
  logic [12:0] dpos = '0;
  logic [11:0] dxy = '0;
  logic [15:0] dwd = '0;
  logic [14:0] ma;
  logic [3:0] cmd;
  logic [5:0] bsel;
  logic [7:0] pr, pg, pb, pidx;
  logic [15:0] zv;
  logic tal;
  int err_total = 0, checks_done = 0, refs = 0;
  int ord[$];
  always #2.5 clk = ~clk;
  gmc_top dut_u (.I_MCLK(clk), .I_RST(rst), .i_MEMORY_TYPE_CONFIG(mt),
    .i_HOST_REQ(req[3]), .i_HOST_WE(we), .i_HOST_ADDR(haddr), .i_HOST_BE(be),
    .i_HOST_WDATA(hwd), .i_CAP_REQ(req[1]), .i_CAP_ADDR(caddr), .i_CAP_Y0(y0),
    .i_CAP_CB(cb), .i_CAP_Y1(y1), .i_CAP_CR(cr), .i_DISP_REQ(req[2]),
    .i_DISP_CURSOR(cur), .i_DISP_LAYER(dl), .i_DISP_X(dpos), .i_DISP_Y(dpos),
    .i_VBLANK(vbl), .i_AUTO_FLIP(aflip), .i_FLIP_REQ(freq), .i_DBUF_EN(dben),
    .i_LAYER_ORG_A('0), .i_LAYER_ORG_B({NLAYER{25'h080000}}), .i_LAYER_FMT(fmt),
    .i_LAYER_W32({NLAYER{8'h01}}), .i_LAYER_H({NLAYER{13'h0020}}), .i_CUR_BASE('0),
    .i_DRW_REQ(req[4]), .i_DRW_WE(dwe), .i_DRW_KIND(dkind), .i_DRW_16BPP(d16),
    .i_DRW_X(dxy), .i_DRW_Y(dxy), .i_DRW_WDATA(dwd), .i_DRW_BASE(dbase),
    .i_DRW_W32(dw32), .o_MEMORY_ADDRESS_OUTPUTS(ma), .o_MEM_CS_N(cmd[3]),
    .o_MEM_RAS_N(cmd[2]), .o_MEM_CAS_N(cmd[1]), .o_MEM_WE_N(cmd[0]), .o_MEM_DQM(dqm),
    .o_MEM_DQ_OUT(dqo), .o_MEM_DQ_OE(oe), .i_MEM_DQ_IN(dqi), .o_ACK(ack),
    .o_RDATA(rdata), .o_PIX_R(pr), .o_PIX_G(pg), .o_PIX_B(pb), .o_PIX_ALPHA(pal),
    .o_PIX_IDX(pidx), .o_PIX_IS_IDX(pisx), .o_DRW_Z(zv), .o_TEX_ALPHA(tal),
    .o_DISP_BUF_SEL(bsel));
  gmc_mem_model mem_u (.i_clk(clk), .i_ma(ma), .i_cmd(cmd), .i_dqm(dqm), .i_dq(dqo),
    .o_dq(dqi));
  // refresh has no acknowledge, so count its command on the pins
  always @(posedge clk) if (cmd === CMD_REF) refs++;
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bank pins picked per memory type
  function automatic logic [1:0] bank_of(logic [14:0] m);
    case (mt)
      MT_SD256X16: return m[14:13];
      MT_SD64X32: return m[12:11];
      MT_FC16X16: return {1'b0, m[11]};
      default: return m[13:12];
    endcase
  endfunction
  function automatic logic [31:0] merge(logic [31:0] a, logic [31:0] b, logic [3:0] e);
    for (int i = 0; i < 4; i++)
      if (e[i]) a[8*i+:8] = b[8*i+:8];
    return a;
  endfunction
  // request held until its acknowledge, dropped in the ack cycle
  task automatic wait_ack(int i);
    int n;
    for (n = 0; n < 60; n++) begin
      tick();
      // only a host row open once capture and display are served
      if (cmd === CMD_ACT && i == 3 && req[2:1] == 2'b00)
        check("bank", bank_of(ma), mt == MT_FC16X16 ? {1'b0, haddr[10]} : haddr[11:10]);
      if (ack[i] === 1'b1) break;
    end
    req[i] = 1'b0;
    ord.push_back(i);
    check("ack", n < 60, 1'b1);
    tick();
  endtask
  task automatic host(logic w, logic [24:0] a, logic [3:0] b, logic [31:0] d);
    we = w;
    haddr = a;
    be = b;
    hwd = d;
    req[3] = 1'b1;
    wait_ack(3);
    r = rdata;
  endtask
  task automatic drw(gmc_drwkind_t k, logic w);
    dkind = k;
    dwe = w;
    req[4] = 1'b1;
    wait_ack(4);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    logic [24:0] a;
    logic [31:0] w2;
    logic [3:0] b;
    foreach (fmt[j]) fmt[j] = PF_RGB16;
    void'($urandom(32'habe1));
    tick(12);
    rst = 1'b0;
    for (int i = 0; i < 60; i++) begin
      mt = gmc_memtype_t'($urandom_range(5));
      a = 25'($urandom) & 25'h1fffffc;
      v = $urandom;
      w2 = $urandom;
      b = i == 0 ? 4'h0 : i == 1 ? 4'hf : 4'($urandom);
      host(1'b1, a, 4'hf, v);
      host(1'b1, a, b, w2);
      host(1'b0, a, 4'h0, 32'h0);
      check("rdata", r, merge(v, w2, b));
    end
    mt = MT_SD64X16;
    v = $urandom;
    host(1'b1, 25'h0, 4'hf, v);
    caddr = 25'h000800;
    {y0, cb, y1, cr} = $urandom;
    dxy = 12'($urandom);
    dwd = 16'($urandom);
    haddr = 25'h0;
    we = 1'b0;
    ord.delete();
    req[4:1] = 4'hf;
    fork
      wait_ack(1);
      wait_ack(2);
      wait_ack(3);
      wait_ack(4);
    join
    check("order", {ord[0][7:0], ord[1][7:0], ord[2][7:0], ord[3][7:0]}, 32'h01020304);
    check("host_rd", rdata, v);
    check("alpha", pal, v[15]);
    check("is_idx", pisx, 1'b0);
    check("rgb16", {pr[7:3], pg[7:3], pb[7:3]}, v[14:0]);
    host(1'b0, caddr, 4'h0, 32'h0);
    check("capture", r, {y1, cr, y0, cb});
    // position 40 in a 32x32 frame wraps to pixel (8,8), byte 0x108
    v = $urandom;
    host(1'b1, 25'h000108, 4'hf, v);
    fmt[1] = PF_IDX8;
    dl = 3'h1;
    dpos = 13'd40;
    req[2] = 1'b1;
    wait_ack(2);
    check("idx", {pisx, pidx}, {1'b1, v[7:0]});
    v = $urandom;
    host(1'b1, 25'h000420, 4'hf, v);
    fmt[1] = PF_RGB32;
    req[2] = 1'b1;
    wait_ack(2);
    check("rgb32", {pal, pr, pg, pb}, {v[31], v[23:0]});
    // cursor pixel (40,40) at 64 bytes a line
    v = $urandom;
    host(1'b1, 25'h000a28, 4'hf, v);
    cur = 1'b1;
    req[2] = 1'b1;
    wait_ack(2);
    check("cursor", {pisx, pidx}, {1'b1, v[7:0]});
    // pixel (3,3): depth at base+0xc6, flag byte at base+0x10
    dxy = 12'h003;
    dwd = 16'($urandom);
    drw(DK_DEPTH, 1'b1);
    drw(DK_DEPTH, 1'b0);
    check("depth", zv, dwd);
    host(1'b0, 25'h1000c4, 4'h0, 32'h0);
    check("depth_lane", r[31:16], dwd);
    drw(DK_TEX, 1'b0);
    check("tex_alpha", tal, dwd[15]);
    drw(DK_FLAG, 1'b1);
    host(1'b0, 25'h100010, 4'h0, 32'h0);
    check("flag", r[7:0], dwd[7:0]);
    dben = 4'b0001;
    freq = 4'b0011;
    tick();
    freq = 4'b0000;
    tick(3);
    check("no_flip", bsel, 6'h00);
    vbl = 1'b1;
    tick(3);
    check("flip", bsel, 6'h04);
    vbl = 1'b0;
    aflip = 1'b1;
    tick(2);
    vbl = 1'b1;
    tick(3);
    check("auto_flip", bsel, 6'h00);
    check("refresh", refs > 0, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
